// >>> design/eis_consts.vh
`ifndef EIS_CONSTS_VH
`define EIS_CONSTS_VH

// sense field codes
`define EIS_SENSE_FALL     2'b00
`define EIS_SENSE_RISE     2'b01
`define EIS_SENSE_LOW      2'b10
`define EIS_SENSE_RSVD     2'b11
`define EIS_SENSE_RESET    2'b00

// field positions in the 16-bit control word
`define EIS_P2_LO          4
`define EIS_P2_HI          5
`define EIS_P3_LO          6
`define EIS_P3_HI          7
`define EIS_P4_LO          8
`define EIS_P4_HI          9
`define EIS_P5_LO          10
`define EIS_P5_HI          11

`define EIS_CTRL_W         16
`define EIS_NCH            4
`define EIS_CTRL_RESET     16'h0000
`define EIS_CH_ZERO        4'h0

// channel index inside the flag and clear vectors
`define EIS_CH_P2          0
`define EIS_CH_P3          1
`define EIS_CH_P4          2
`define EIS_CH_P5          3

// single-bit levels
`define EIS_BIT_SET        1'b1
`define EIS_BIT_CLR        1'b0
`define EIS_PIN_IDLE       1'b1
`define EIS_FLAG_RESET     1'b0

`endif

// >>> design/eis_sense_select.v
// Notes on behaviour
// - pin five field decodes 00 falling, 01 rising, 10 held low.
// - pin four sense taken from control bits 9 and 8.
// - pin three sense taken from control bits 7 and 6.
// - pin two sense taken from control bits 5 and 4.
// - low-level sense requests for as long as the pin stays low.
// - pin five field at bits 11 and 10, readable and writable.
// - edge request stays pending until cleared; level request follows the pin.
`timescale 1ns/1ps
`default_nettype none
`include "eis_consts.vh"

module eis_sense_select (
	input  wire        CLK,
	input  wire        RST,
	input  wire        CTRL_WE,
	input  wire [15:0] CTRL_WDATA,
	input  wire [3:0]  FLAG_CLR,
	input  wire        EXT_REQUEST_PIN2,
	input  wire        EXT_REQUEST_PIN3,
	input  wire        EXT_REQUEST_PIN4,
	input  wire        EXT_REQUEST_PIN5,
	output wire [15:0] CTRL_RDATA,
	output wire [3:0]  REQUEST_FLAG
);

	// control word: only the eight sense bits hold state
	reg  [15:0] ctrl_q;
	reg  [15:0] ctrl_d;

	// sense codes per channel
	wire [1:0]  sense_p2;
	wire [1:0]  sense_p3;
	wire [1:0]  sense_p4;
	wire [1:0]  sense_p5;

	// pin history for edge detection
	reg         pin_p2_q;
	reg         pin_p3_q;
	reg         pin_p4_q;
	reg         pin_p5_q;

	// raw detections this cycle
	reg         det_p2;
	reg         det_p3;
	reg         det_p4;
	reg         det_p5;

	// request flags
	reg         flag_p2_q;
	reg         flag_p2_d;
	reg         flag_p3_q;
	reg         flag_p3_d;
	reg         flag_p4_q;
	reg         flag_p4_d;
	reg         flag_p5_q;
	reg         flag_p5_d;

	// two-bit sense field at the given bit pair
	function [1:0] field_at;
		input [15:0] c;
		input integer hi;
		input integer lo;
		begin
			field_at = {c[hi], c[lo]};
		end
	endfunction

	// reserved code detects nothing rather than guess
	function detect;
		input [1:0] mode;
		input       prev;
		input       now;
		begin
			case (mode)
				`EIS_SENSE_FALL: begin
					detect = prev & ~now;
				end
				`EIS_SENSE_RISE: begin
					detect = ~prev & now;
				end
				`EIS_SENSE_LOW: begin
					detect = ~now;
				end
				default: begin
					detect = `EIS_BIT_CLR;
				end
			endcase
		end
	endfunction

	// set beats a same-cycle clear so no edge is lost
	function flag_next;
		input [1:0] mode;
		input       det;
		input       clr;
		input       flag;
		begin
			if (mode == `EIS_SENSE_LOW) begin
				flag_next = det;
			end else if (det) begin
				flag_next = `EIS_BIT_SET;
			end else if (clr) begin
				flag_next = `EIS_BIT_CLR;
			end else begin
				flag_next = flag;
			end
		end
	endfunction

	assign sense_p2 = field_at(ctrl_q, `EIS_P2_HI, `EIS_P2_LO);
	assign sense_p3 = field_at(ctrl_q, `EIS_P3_HI, `EIS_P3_LO);
	assign sense_p4 = field_at(ctrl_q, `EIS_P4_HI, `EIS_P4_LO);
	assign sense_p5 = field_at(ctrl_q, `EIS_P5_HI, `EIS_P5_LO);

	// unused bits read as zero
	always @* begin
		ctrl_d = ctrl_q;
		if (CTRL_WE) begin
			ctrl_d = `EIS_CTRL_RESET;
			ctrl_d[`EIS_P5_HI:`EIS_P2_LO] = CTRL_WDATA[`EIS_P5_HI:`EIS_P2_LO];
		end
	end

	// pin two
	always @* begin
		det_p2    = detect(sense_p2, pin_p2_q, EXT_REQUEST_PIN2);
		flag_p2_d = flag_next(sense_p2, det_p2, FLAG_CLR[`EIS_CH_P2], flag_p2_q);
	end

	// pin three
	always @* begin
		det_p3    = detect(sense_p3, pin_p3_q, EXT_REQUEST_PIN3);
		flag_p3_d = flag_next(sense_p3, det_p3, FLAG_CLR[`EIS_CH_P3], flag_p3_q);
	end

	// pin four
	always @* begin
		det_p4    = detect(sense_p4, pin_p4_q, EXT_REQUEST_PIN4);
		flag_p4_d = flag_next(sense_p4, det_p4, FLAG_CLR[`EIS_CH_P4], flag_p4_q);
	end

	// pin five
	always @* begin
		det_p5    = detect(sense_p5, pin_p5_q, EXT_REQUEST_PIN5);
		flag_p5_d = flag_next(sense_p5, det_p5, FLAG_CLR[`EIS_CH_P5], flag_p5_q);
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_q <= `EIS_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// history resets high, so a pin already low at release is seen as a falling edge
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_p2_q <= `EIS_PIN_IDLE;
		end else begin
			pin_p2_q <= EXT_REQUEST_PIN2;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			flag_p2_q <= `EIS_FLAG_RESET;
		end else begin
			flag_p2_q <= flag_p2_d;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_p3_q <= `EIS_PIN_IDLE;
		end else begin
			pin_p3_q <= EXT_REQUEST_PIN3;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			flag_p3_q <= `EIS_FLAG_RESET;
		end else begin
			flag_p3_q <= flag_p3_d;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_p4_q <= `EIS_PIN_IDLE;
		end else begin
			pin_p4_q <= EXT_REQUEST_PIN4;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			flag_p4_q <= `EIS_FLAG_RESET;
		end else begin
			flag_p4_q <= flag_p4_d;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			pin_p5_q <= `EIS_PIN_IDLE;
		end else begin
			pin_p5_q <= EXT_REQUEST_PIN5;
		end
	end

	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			flag_p5_q <= `EIS_FLAG_RESET;
		end else begin
			flag_p5_q <= flag_p5_d;
		end
	end

	assign CTRL_RDATA   = ctrl_q;
	assign REQUEST_FLAG = {flag_p5_q, flag_p4_q, flag_p3_q, flag_p2_q};

endmodule // eis_sense_select

`default_nettype wire

// >>> tb/eis_properties.sv
`timescale 1ns/1ps
`default_nettype none
module eis_props(input wire logic CLK, RST, CTRL_WE, EXT_REQUEST_PIN2, EXT_REQUEST_PIN3,
	EXT_REQUEST_PIN4, EXT_REQUEST_PIN5, input wire logic [15:0] CTRL_WDATA, CTRL_RDATA,
	input wire logic [3:0] FLAG_CLR, REQUEST_FLAG);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_wr; CTRL_WE |=> CTRL_RDATA == ($past(CTRL_WDATA) & 16'h0ff0); endproperty
	a_wr: assert property (p_wr) else $error("readback");
	property p_rise;
		CTRL_RDATA[5:4] == 2'b01 && $rose(EXT_REQUEST_PIN2) |=> REQUEST_FLAG[0];
	endproperty
	a_rise: assert property (p_rise) else $error("rise");
	property p_fall;
		CTRL_RDATA[7:6] == 2'b00 && $fell(EXT_REQUEST_PIN3) |=> REQUEST_FLAG[1];
	endproperty
	a_fall: assert property (p_fall) else $error("fall");
	property p_lvl; $past(CTRL_RDATA[9:8]) == 2'b10 |-> REQUEST_FLAG[2] == !$past(EXT_REQUEST_PIN4);
	endproperty
	a_lvl: assert property (p_lvl) else $error("level");
	property p_hold; REQUEST_FLAG[3] && CTRL_RDATA[11:10] != 2'b10 && !FLAG_CLR[3] |=> REQUEST_FLAG[3];
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	sequence s_clr_pin2;
		FLAG_CLR[0] && CTRL_RDATA[5:4] == 2'b01 && !$rose(EXT_REQUEST_PIN2);
	endsequence
	property p_clr; s_clr_pin2 |=> !REQUEST_FLAG[0]; endproperty
	a_clr: assert property (p_clr) else $error("clear");
endmodule // eis_props
bind eis_sense_select eis_props eis_props_inst(.*);
`default_nettype wire

// >>> tb/eis_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module eis_src_model(input wire logic CLK, input wire logic [3:0] LVL, output logic [3:0] PIN = 4'hf);
	always @(posedge CLK) PIN <= LVL; // idle high so reset release sees no edge
endmodule // eis_src_model
`default_nettype wire

// >>> tb/tb_eis_sense_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eis_sense_select;
	logic        CLK = 0, RST = 1, we = 0;
	logic [15:0] wd = 0, rd;
	logic [3:0]  clr = 0, lvl = 4'hf, pin, flag;
	int          err_count, total_checks, cyc;
	eis_src_model eis_src_model_inst(.CLK(CLK), .LVL(lvl), .PIN(pin));
	eis_sense_select eis_sense_select_inst(.CLK(CLK), .RST(RST), .CTRL_WE(we), .CTRL_WDATA(wd),
		.FLAG_CLR(clr), .EXT_REQUEST_PIN2(pin[0]), .EXT_REQUEST_PIN3(pin[1]),
		.EXT_REQUEST_PIN4(pin[2]), .EXT_REQUEST_PIN5(pin[3]), .CTRL_RDATA(rd), .REQUEST_FLAG(flag));
	initial forever #25 CLK = ~CLK;
	task chk(logic [15:0] s, e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	task wr(logic [15:0] d);
		@(posedge CLK);
		we <= 1;
		wd <= d;
		@(posedge CLK);
		we <= 0;
		#1;
	endtask
	task pins(logic [3:0] v);
		@(posedge CLK);
		lvl <= v;
		repeat (4) @(posedge CLK);
		#1;
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge CLK) if (++cyc == 400) begin
		err_count++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge CLK);
		RST <= 0;
		@(posedge CLK) #1;
		chk(rd, 0);
		wr(16'hf21f);
		chk(rd, 16'h0210);
		pins(4'h0);
		chk(flag, 4'he);
		pins(4'hf);
		chk(flag, 4'hb);
		@(posedge CLK);
		clr <= 4'hf;
		@(posedge CLK);
		clr <= 0;
		#1;
		chk(flag, 0);
		wr(16'h0480);
		pins(4'h0);
		chk(flag, 4'h7);
		pins(4'hf);
		chk(flag, 4'hd);
		close_out;
	end
endmodule // tb_eis_sense_select
`default_nettype wire
